// File: logic/pss_pkg.sv
// constants, types and register map of the program sequencer with return stack
// assumes a single 100 MHz clock domain and an axi4-lite register master
package pss_pkg;

	// ------------------------------------------------------------
	// widths and sizes
	// ------------------------------------------------------------
	localparam int PSS_PC_W         = 12;
	localparam int PSS_INSTR_W      = 15;
	localparam int PSS_STACK_LEVELS = 8;
	localparam int PSS_IRQ_N        = 6;
	localparam int PSS_PHASES       = 4;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int PSS_CLK_PERIOD_NS     = 10;
	localparam int PSS_SYS_PERIOD_NS     = 10;
	localparam int PSS_STARTUP_SYS_TICKS = 1024;
	localparam int PSS_STARTUP_CYCLES    =
		(PSS_STARTUP_SYS_TICKS * PSS_SYS_PERIOD_NS + PSS_CLK_PERIOD_NS - 1) / PSS_CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// program counter targets
	// ------------------------------------------------------------
	localparam logic [11:0] PSS_RESET_VEC = 12'h000;
	localparam logic [3:0]  PSS_LAST_PAGE = 4'hf;
	// index 0 is ext line zero, 5 is real time clock; lowest index wins
	localparam logic [5:0][11:0] PSS_IRQ_VEC = {12'h018, 12'h014, 12'h010, 12'h00c, 12'h008, 12'h004};

	// ------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0] PSS_IDX_PC_LOW_BYTE   = 8'h06;
	localparam logic [7:0] PSS_IDX_TABLE_POINTER = 8'h07;
	localparam logic [7:0] PSS_IDX_TABLE_HIGH    = 8'h08;
	localparam logic [7:0] PSS_IDX_IRQ_CTRL      = 8'h10;
	localparam logic [7:0] PSS_IDX_IRQ_FLAG      = 8'h11;
	localparam logic [7:0] PSS_IDX_SEQ_STAT      = 8'h12;

	// field positions and reset values
	localparam int         PSS_GLOBAL_EN_BIT = 7;
	localparam int         PSS_STAT_PC_LSB   = 16;
	localparam logic [7:0] PSS_TABLE_PTR_RST = 8'h00;
	localparam logic [5:0] PSS_IRQ_EN_RST    = 6'h00;
	localparam logic [1:0] PSS_RESP_OKAY     = 2'h0;
	localparam logic [1:0] PSS_RESP_SLVERR   = 2'h2;

	// ------------------------------------------------------------
	// execute-stage commands
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		PSS_OP_NONE,
		PSS_OP_SKIP,
		PSS_OP_JUMP,
		PSS_OP_CALL,
		PSS_OP_SUBROUTINE_RETURN,
		PSS_OP_INTERRUPT_RETURN,
		PSS_OP_PC_LOW_WRITE,
		PSS_OP_TABLE_READ_CURRENT_PAGE,
		PSS_OP_TABLE_READ_LAST_PAGE
	} pss_op_e;

	typedef struct packed {
		pss_op_e     op;
		logic [11:0] target;
		logic [7:0]  data;
	} pss_cmd_s;

endpackage : pss_pkg

// File: logic/pss_sequencer.sv
// program sequencer: phase generator, fetch/execute pipeline, pc, table reads,
// interrupt vectoring and the eight-level return stack, with an axi4-lite slave
// assumes a synchronous program memory that returns data one clock after address
// and a decoder that presents exec_cmd for instr_word during phase 3
//
// Contract
// [RL1] four clocks make one instruction cycle
// [RL2] fetch overlaps execute of previous instruction
// [RL3] pc-changing instructions cost a dummy cycle
// [RL4] pc advances by one after fetch
// [RL5] met skip drops prefetch, resumes pc plus two
// [RL6] low-byte write jumps within current page
// [RL7] 4096 words of 15 bits, 12-bit addresses
// [RL8] reset starts execution at address zero
// [RL9] ext lines vector to 004h and 008h
// [RL10] timer overflow vectors to 00ch
// [RL11] time base time-out vectors to 010h
// [RL12] converter end vectors to 014h
// [RL13] real time clock vectors to 018h
// [RL14] table address: page bits plus pointer
// [RL15] table word splits low byte, high seven
// [RL16] pointer read/write, table high read-only
// [RL17] table reads take two instruction cycles
// [RL18] eight-level stack holds only pc values
// [RL19] call/irq push, returns pop the pc
// [RL20] reset leaves stack index at top
// [RL21] full stack holds interrupt pending, unacknowledged
// [RL22] call on full stack loses oldest entry
// [RL23] acknowledge clears source flag and global enable
// [RL24] lowest vector wins among simultaneous requests
// [RL25] interrupt return sets global enable again
module pss_sequencer
	import pss_pkg::*;
#(
	parameter int STACK_DEPTH = PSS_STACK_LEVELS,
	parameter int ADDR_W      = 12
)(
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [ADDR_W-1:0]       s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// program memory
	output logic [PSS_PC_W-1:0]          pmem_addr,
	input  wire logic [PSS_INSTR_W-1:0]  pmem_rdata,
	// decoder side
	output logic [PSS_PHASES-1:0]        phase_strb,
	output logic [PSS_INSTR_W-1:0]       instr_word,
	output logic                         instr_valid,
	input  wire pss_pkg::pss_cmd_s       exec_cmd,
	output logic [7:0]                   table_low_data,
	output logic                         table_low_valid,
	// interrupt sources
	input  wire logic [PSS_IRQ_N-1:0]    irq_event
);
	import pss_pkg::*;

	localparam int PW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
	localparam int CW = $clog2(STACK_DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(STACK_DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(STACK_DEPTH - 1);
	localparam logic [10:0]   STARTUP_LAST = 11'(PSS_STARTUP_CYCLES - 1);

	function automatic logic [PW-1:0] ptr_dec(input logic [PW-1:0] p);
		ptr_dec = (p == '0) ? LAST_PTR : p - PW'(1);
	endfunction : ptr_dec

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == LAST_PTR) ? '0 : p + PW'(1);
	endfunction : ptr_inc

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[9:2];
		if (a[ADDR_W-1:10] != '0 || a[1:0] != 2'h0)
			reg_mapped = 1'b0;
		else if (idx == PSS_IDX_PC_LOW_BYTE || idx == PSS_IDX_TABLE_POINTER || idx == PSS_IDX_TABLE_HIGH)
			reg_mapped = 1'b1;
		else if (idx == PSS_IDX_IRQ_CTRL || idx == PSS_IDX_IRQ_FLAG || idx == PSS_IDX_SEQ_STAT)
			reg_mapped = 1'b1;
		else
			reg_mapped = 1'b0;
	endfunction : reg_mapped

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [1:0]             phase_ff;
	logic [3:0]             phase_strb_ff;
	logic [10:0]            startup_cnt_ff;
	logic                   run_ff;
	logic [PSS_PC_W-1:0]    pc_ff;
	logic [PSS_PC_W-1:0]    pmem_addr_ff;
	logic [PSS_INSTR_W-1:0] fetch_word_ff;
	logic [PSS_INSTR_W-1:0] ir_ff;
	logic                   ir_valid_ff;
	logic                   tab_busy_ff;
	logic [7:0]             table_pointer_ff;
	logic [6:0]             table_high_ff;
	logic [7:0]             table_low_ff;
	logic                   table_low_valid_ff;
	logic [PSS_PC_W-1:0]    stack_mem_ff [STACK_DEPTH];
	logic [PW-1:0]          stack_ptr_ff;
	logic [CW-1:0]          stack_index_ff;
	logic [PSS_IRQ_N-1:0]   irq_flag_ff;
	logic [PSS_IRQ_N-1:0]   irq_en_ff;
	logic                   global_irq_enable_ff;
	logic [ADDR_W-1:0]      aw_addr_ff;
	logic                   aw_got_ff;
	logic [31:0]            w_data_ff;
	logic [3:0]             w_strb_ff;
	logic                   w_got_ff;
	logic                   awready_ff;
	logic                   wready_ff;
	logic                   bvalid_ff;
	logic [1:0]             bresp_ff;
	logic                   arready_ff;
	logic                   rvalid_ff;
	logic [31:0]            rdata_ff;
	logic [1:0]             rresp_ff;

	// ------------------------------------------------------------
	// phase generator and start-up delay
	// ------------------------------------------------------------
	// [RL1] four-phase rotation
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			phase_ff      <= 2'h0;
			phase_strb_ff <= 4'h1;
		end
		else
		begin
			phase_ff      <= phase_ff + 2'h1;
			phase_strb_ff <= {phase_strb_ff[2:0], phase_strb_ff[3]};
		end
	end

	// run starts on an instruction-cycle boundary so fetch lines up with phase 0
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			startup_cnt_ff <= 11'h000;
			run_ff         <= 1'b0;
		end
		else if (!run_ff)
		begin
			if (startup_cnt_ff != STARTUP_LAST)
				startup_cnt_ff <= startup_cnt_ff + 11'h001;
			else if (phase_ff == 2'h3)
				run_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// next program counter
	// ------------------------------------------------------------
	logic                  end_cyc;
	logic                  exec_live;
	pss_op_e               op;
	logic [PSS_IRQ_N-1:0]  irq_pend;
	logic                  stack_full;
	logic                  irq_take;
	logic [2:0]            irq_sel;
	logic [PSS_PC_W-1:0]   table_addr;
	logic [PSS_PC_W-1:0]   stack_top;
	logic [PSS_PC_W-1:0]   nxt_pc;
	logic [PSS_PC_W-1:0]   nxt_pmem_addr;
	logic                  nxt_ir_valid;
	logic                  push;
	logic                  pop;
	logic                  tab_start;

	assign end_cyc    = run_ff && (phase_ff == 2'h3);
	assign exec_live  = ir_valid_ff && !tab_busy_ff;
	assign op         = exec_live ? exec_cmd.op : PSS_OP_NONE;
	assign irq_pend   = irq_flag_ff & irq_en_ff & {PSS_IRQ_N{global_irq_enable_ff}};
	assign stack_full = (stack_index_ff == FULL_CNT);
	assign stack_top  = stack_mem_ff[ptr_dec(stack_ptr_ff)];

	// [RL21] full stack holds acknowledge
	assign irq_take = end_cyc && !tab_busy_ff && (op == PSS_OP_NONE) && (|irq_pend) && !stack_full;

	// [RL24] lowest vector priority
	always_comb
	begin
		irq_sel = 3'h0;
		for (int i = PSS_IRQ_N - 1; i >= 0; i--)
			if (irq_pend[i])
				irq_sel = 3'(i);
	end

	// [RL14] table address forming
	assign table_addr = {(op == PSS_OP_TABLE_READ_LAST_PAGE) ? PSS_LAST_PAGE : pc_ff[11:8], table_pointer_ff};

	always_comb
	begin
		// [RL4] default increment
		nxt_pc       = pc_ff + 12'h001;
		nxt_ir_valid = 1'b1;
		push         = 1'b0;
		pop          = 1'b0;
		tab_start    = 1'b0;
		if (tab_busy_ff)
		begin
			// second table cycle refetches the held pc
			nxt_pc = pc_ff;
		end
		else if (irq_take)
		begin
			// [RL9] [RL10] [RL11] [RL12] [RL13] vector branch
			push         = 1'b1;
			nxt_pc       = PSS_IRQ_VEC[irq_sel];
			nxt_ir_valid = 1'b0;
		end
		else
		begin
			// [RL3] transfers insert dummy cycle
			case (op)
				PSS_OP_SKIP:
				begin
					// [RL5] discard prefetch, pc plus two
					nxt_ir_valid = 1'b0;
				end
				PSS_OP_JUMP:
				begin
					nxt_pc       = exec_cmd.target;
					nxt_ir_valid = 1'b0;
				end
				PSS_OP_CALL:
				begin
					push         = 1'b1;
					nxt_pc       = exec_cmd.target;
					nxt_ir_valid = 1'b0;
				end
				PSS_OP_SUBROUTINE_RETURN, PSS_OP_INTERRUPT_RETURN:
				begin
					// [RL19] restore from stack
					pop          = 1'b1;
					nxt_pc       = stack_top;
					nxt_ir_valid = 1'b0;
				end
				PSS_OP_PC_LOW_WRITE:
				begin
					// [RL6] short jump in page
					nxt_pc       = {pc_ff[11:8], exec_cmd.data};
					nxt_ir_valid = 1'b0;
				end
				PSS_OP_TABLE_READ_CURRENT_PAGE, PSS_OP_TABLE_READ_LAST_PAGE:
				begin
					tab_start = 1'b1;
				end
				default:
				begin
					tab_start = 1'b0;
				end
			endcase
		end
		nxt_pmem_addr = tab_start ? table_addr : nxt_pc;
	end

	// ------------------------------------------------------------
	// fetch / execute pipeline
	// ------------------------------------------------------------
	// [RL7] 12-bit fetch of 15-bit words
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fetch_word_ff <= 15'h0000;
		else if (run_ff && phase_ff == 2'h2)
			fetch_word_ff <= pmem_rdata;
	end

	// [RL2] fetched word moves to execute
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// [RL8] start at address zero
			pc_ff        <= PSS_RESET_VEC;
			pmem_addr_ff <= PSS_RESET_VEC;
			ir_ff        <= 15'h0000;
			ir_valid_ff  <= 1'b0;
			tab_busy_ff  <= 1'b0;
		end
		else if (end_cyc)
		begin
			pc_ff        <= nxt_pc;
			pmem_addr_ff <= nxt_pmem_addr;
			ir_valid_ff  <= nxt_ir_valid;
			// [RL17] table read holds pipeline one cycle
			tab_busy_ff  <= tab_start;
			if (!tab_busy_ff)
				ir_ff <= fetch_word_ff;
		end
	end

	// [RL15] split table word
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			table_low_ff       <= 8'h00;
			table_high_ff      <= 7'h00;
			table_low_valid_ff <= 1'b0;
		end
		else
		begin
			table_low_valid_ff <= end_cyc && tab_busy_ff;
			if (end_cyc && tab_busy_ff)
			begin
				table_low_ff  <= fetch_word_ff[7:0];
				table_high_ff <= fetch_word_ff[14:8];
			end
		end
	end

	// ------------------------------------------------------------
	// return stack
	// ------------------------------------------------------------
	// [RL18] pc-only storage, no bus path
	always_ff @(posedge aclk)
	begin
		if (end_cyc && push)
			stack_mem_ff[stack_ptr_ff] <= pc_ff;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// [RL20] index at top after reset
			stack_ptr_ff   <= '0;
			stack_index_ff <= '0;
		end
		else if (end_cyc && push)
		begin
			// [RL22] ring overwrites oldest when full
			stack_ptr_ff <= ptr_inc(stack_ptr_ff);
			if (!stack_full)
				stack_index_ff <= stack_index_ff + CW'(1);
		end
		else if (end_cyc && pop)
		begin
			stack_ptr_ff <= ptr_dec(stack_ptr_ff);
			if (stack_index_ff != '0)
				stack_index_ff <= stack_index_ff - CW'(1);
		end
	end

	// ------------------------------------------------------------
	// interrupt flags and enables
	// ------------------------------------------------------------
	logic                 wr_do;
	logic [7:0]           wr_idx;
	logic [PSS_IRQ_N-1:0] sw_clr;
	logic [PSS_IRQ_N-1:0] ack_clr;

	assign wr_do   = aw_got_ff && w_got_ff && !bvalid_ff;
	assign wr_idx  = aw_addr_ff[9:2];
	assign sw_clr  = (wr_do && reg_mapped(aw_addr_ff) && wr_idx == PSS_IDX_IRQ_FLAG && w_strb_ff[0]) ?
		w_data_ff[PSS_IRQ_N-1:0] : '0;
	assign ack_clr = irq_take ? (PSS_IRQ_N'(1) << irq_sel) : '0;

	// set beats any same-cycle clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_flag_ff <= '0;
		else
			irq_flag_ff <= (irq_flag_ff & ~sw_clr & ~ack_clr) | irq_event;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_en_ff            <= PSS_IRQ_EN_RST;
			global_irq_enable_ff <= 1'b0;
		end
		else
		begin
			if (wr_do && reg_mapped(aw_addr_ff) && wr_idx == PSS_IDX_IRQ_CTRL && w_strb_ff[0])
			begin
				irq_en_ff            <= w_data_ff[PSS_IRQ_N-1:0];
				global_irq_enable_ff <= w_data_ff[PSS_GLOBAL_EN_BIT];
			end
			// [RL23] acknowledge blocks nesting
			if (irq_take)
				global_irq_enable_ff <= 1'b0;
			// [RL25] interrupt return re-enables
			else if (end_cyc && op == PSS_OP_INTERRUPT_RETURN)
				global_irq_enable_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			aw_addr_ff <= '0;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && awready_ff)
			begin
				aw_got_ff  <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end
			else if (wr_do)
				aw_got_ff <= 1'b0;
			else if (!aw_got_ff)
				awready_ff <= 1'b1;
			if (s_axi_wvalid && wready_ff)
			begin
				w_got_ff  <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
				wready_ff <= 1'b0;
			end
			else if (wr_do)
				w_got_ff <= 1'b0;
			else if (!w_got_ff)
				wready_ff <= 1'b1;
		end
	end

	// [RL16] pointer writable, table high refuses writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			table_pointer_ff <= PSS_TABLE_PTR_RST;
			bvalid_ff        <= 1'b0;
			bresp_ff         <= PSS_RESP_OKAY;
		end
		else if (wr_do)
		begin
			bvalid_ff <= 1'b1;
			if (!reg_mapped(aw_addr_ff))
				bresp_ff <= PSS_RESP_SLVERR;
			else if (wr_idx == PSS_IDX_TABLE_POINTER || wr_idx == PSS_IDX_IRQ_CTRL || wr_idx == PSS_IDX_IRQ_FLAG)
				bresp_ff <= PSS_RESP_OKAY;
			else
				bresp_ff <= PSS_RESP_SLVERR;
			if (reg_mapped(aw_addr_ff) && wr_idx == PSS_IDX_TABLE_POINTER && w_strb_ff[0])
				table_pointer_ff <= w_data_ff[7:0];
		end
		else if (bvalid_ff && s_axi_bready)
			bvalid_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	logic [31:0] rd_word;
	logic [7:0]  rd_idx;

	assign rd_idx = s_axi_araddr[9:2];

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (rd_idx == PSS_IDX_PC_LOW_BYTE)
			rd_word[7:0] = pc_ff[7:0];
		else if (rd_idx == PSS_IDX_TABLE_POINTER)
			rd_word[7:0] = table_pointer_ff;
		else if (rd_idx == PSS_IDX_TABLE_HIGH)
			rd_word[6:0] = table_high_ff;
		else if (rd_idx == PSS_IDX_IRQ_CTRL)
		begin
			rd_word[PSS_IRQ_N-1:0] = irq_en_ff;
			rd_word[PSS_GLOBAL_EN_BIT] = global_irq_enable_ff;
		end
		else if (rd_idx == PSS_IDX_IRQ_FLAG)
			rd_word[PSS_IRQ_N-1:0] = irq_flag_ff;
		else if (rd_idx == PSS_IDX_SEQ_STAT)
		begin
			rd_word[CW-1:0] = stack_index_ff;
			rd_word[PSS_STAT_PC_LSB +: PSS_PC_W] = pc_ff;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= PSS_RESP_OKAY;
		end
		else if (s_axi_arvalid && arready_ff)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= reg_mapped(s_axi_araddr) ? rd_word : 32'h0000_0000;
			rresp_ff   <= reg_mapped(s_axi_araddr) ? PSS_RESP_OKAY : PSS_RESP_SLVERR;
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
		else if (!rvalid_ff)
			arready_ff <= 1'b1;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready   = awready_ff;
	assign s_axi_wready    = wready_ff;
	assign s_axi_bvalid    = bvalid_ff;
	assign s_axi_bresp     = bresp_ff;
	assign s_axi_arready   = arready_ff;
	assign s_axi_rvalid    = rvalid_ff;
	assign s_axi_rdata     = rdata_ff;
	assign s_axi_rresp     = rresp_ff;
	assign pmem_addr       = pmem_addr_ff;
	assign phase_strb      = phase_strb_ff;
	assign instr_word      = ir_ff;
	assign instr_valid     = ir_valid_ff;
	assign table_low_data  = table_low_ff;
	assign table_low_valid = table_low_valid_ff;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_phase_walk;
		phase_strb_ff[1] ##1 phase_strb_ff[2] ##1 phase_strb_ff[3] ##1 phase_strb_ff[0];
	endsequence

	sequence s_table_done;
		tab_busy_ff [*4] ##1 (!tab_busy_ff && table_low_valid_ff);
	endsequence

	a_phase_rotation: assert property (phase_strb_ff[0] |=> s_phase_walk) // [RL1]
		else $error("phase strobes out of order");
	a_pc_increment: assert property ( // [RL4]
		end_cyc && !tab_busy_ff && !irq_take && op == PSS_OP_NONE
		|=> pc_ff == $past(pc_ff) + 12'h001 && ir_valid_ff)
		else $error("pc did not advance by one");
	a_skip_two: assert property ( // [RL5]
		end_cyc && !tab_busy_ff && op == PSS_OP_SKIP
		|=> !ir_valid_ff && pc_ff == $past(pc_ff) + 12'h001)
		else $error("skip did not resume at pc plus two");
	// an interrupt taken in the dummy cycle legally adds a second dummy
	a_jump_dummy: assert property ( // [RL3]
		end_cyc && !tab_busy_ff && op == PSS_OP_JUMP
		|=> !ir_valid_ff ##4 (ir_valid_ff || $past(irq_take)))
		else $error("jump did not insert one dummy cycle");
	a_pc_low_page: assert property ( // [RL6]
		end_cyc && !tab_busy_ff && op == PSS_OP_PC_LOW_WRITE
		|=> pc_ff == {$past(pc_ff[11:8]), $past(exec_cmd.data)})
		else $error("low byte write left page");
	a_reset_zero: assert property (!run_ff |-> pmem_addr_ff == PSS_RESET_VEC && pc_ff == PSS_RESET_VEC) // [RL8]
		else $error("fetch not at address zero before start");
	a_irq_vector: assert property (irq_take |=> pc_ff == PSS_IRQ_VEC[$past(irq_sel)] && !global_irq_enable_ff) // [RL9]
		else $error("interrupt vector or enable wrong");
	// a full stack must not vector: the pc keeps counting and the index holds
	a_full_blocks: assert property ( // [RL21]
		end_cyc && stack_full && !tab_busy_ff && op == PSS_OP_NONE
		|=> pc_ff == $past(pc_ff) + 12'h001 && $stable(stack_index_ff))
		else $error("interrupt taken on full stack");
	a_table_two: assert property (end_cyc && tab_start |=> s_table_done) // [RL17]
		else $error("table read not two cycles");
	a_stack_bound: assert property (end_cyc && push && stack_full |=> stack_index_ff == FULL_CNT) // [RL22]
		else $error("stack index passed depth");

endmodule : pss_sequencer

// File: test/pss_testbench.sv
// bench for the program sequencer: registers over axi4-lite, pipeline steered via exec_cmd
// assumes the bench plays program memory (word = 3'b101 above the address) and decoder
module testbench;
	import pss_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t %h %h", $time, g, e); end end
	logic              aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [11:0]       awaddr = 0, araddr = 0, ret_a, rr;
	logic [31:0]       wdata = 0, rdata, seed = 32'd11407, tp, jt;
	logic [3:0]        wstrb = 0, ph;
	logic [14:0]       pmem_rdata = 0, iw;
	pss_cmd_s          cmd = '0;
	logic [5:0]        irq = 0;
	logic              awready, wready, bvalid, arready, rvalid, instr_valid, tlv;
	logic [1:0]        bresp, rresp;
	logic [11:0]       pmem_addr;
	logic [7:0]        tld;
	logic [33:0]       exp_q[$], exp_v;
	int                bad_count = 0, checked = 0, cyc = 0;

	pss_sequencer i_pss_sequencer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pmem_addr(pmem_addr),
		.pmem_rdata(pmem_rdata), .phase_strb(ph), .instr_word(iw), .instr_valid(instr_valid), .exec_cmd(cmd),
		.table_low_data(tld), .table_low_valid(tlv), .irq_event(irq));

	always #5 aclk = ~aclk;

	function automatic logic [14:0] word_at(input logic [11:0] a);
		return {3'b101, a};
	endfunction : word_at

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic stop_test();
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// program memory, result watcher, hang guard
	// ------------------------------------------------------------
	always @(posedge aclk)
	begin
		cyc++;
		// startup alone takes about 1030 clocks
		if (cyc == 4000)
		begin
			bad_count++;
			stop_test();
		end
		pmem_rdata <= word_at(pmem_addr);
		// pop once: the compare macro names its expected value twice
		if (bvalid && bready)
		begin
			exp_v = exp_q.pop_front();
			`CHK({bresp, 32'h0}, exp_v)
		end
		if (rvalid && rready)
		begin
			exp_v = exp_q.pop_front();
			`CHK({rresp, rdata}, exp_v)
		end
	end

	// ------------------------------------------------------------
	// bus and pipeline tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 0;
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		araddr <= a; arvalid <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0; rready <= 1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 0;
	endtask : rd

	// presents a command for the closing edge of a valid instruction cycle
	task automatic op(input pss_op_e o, input logic [11:0] t, input logic [7:0] d);
		do @(posedge aclk); while (!(ph[2] === 1'b1 && instr_valid === 1'b1));
		ret_a = iw[11:0] + 12'h1;
		cmd <= '{o, t, d};
		@(posedge aclk);
		cmd <= '0;
	endtask : op

	// a dummy cycle, then the word at a in the execute stage
	task automatic land(input logic [11:0] a);
		do @(posedge aclk); while (instr_valid !== 1'b0);
		do @(posedge aclk); while (instr_valid !== 1'b1);
		`CHK(iw, word_at(a))
	endtask : land

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		land(PSS_RESET_VEC);
		rd(12'h01c, {PSS_RESP_OKAY, 24'h0, PSS_TABLE_PTR_RST});
		tp = xs();
		wr(12'h01c, {24'h0, tp[7:0]}, PSS_RESP_OKAY);
		rd(12'h01c, {PSS_RESP_OKAY, 24'h0, tp[7:0]});
		wr(12'h020, 32'hff, PSS_RESP_SLVERR);
		rd(12'h0fc, {PSS_RESP_SLVERR, 32'h0});
		op(PSS_OP_TABLE_READ_LAST_PAGE, 12'h0, 8'h0);
		do @(posedge aclk); while (tlv !== 1'b1);
		`CHK(tld, tp[7:0])
		// high part of {3'b101, 4'hf, ptr} is 7'h5f, top bit reads zero
		rd(12'h020, {PSS_RESP_OKAY, 24'h0, 8'h5f});
		jt = xs();
		op(PSS_OP_JUMP, {jt[11:8], 8'h10}, 8'h0);
		land({jt[11:8], 8'h10});
		op(PSS_OP_PC_LOW_WRITE, 12'h0, jt[19:12]);
		land({jt[11:8], jt[19:12]});
		// current page comes from the fetch in flight, one past the table instruction
		op(PSS_OP_TABLE_READ_CURRENT_PAGE, 12'h0, 8'h0);
		do @(posedge aclk); while (tlv !== 1'b1);
		`CHK(tld, tp[7:0])
		rd(12'h020, {PSS_RESP_OKAY, 25'h0, 3'b101, ret_a[11:8]});
		op(PSS_OP_SKIP, 12'h0, 8'h0);
		land(ret_a + 12'h1);
		op(PSS_OP_CALL, 12'h200, 8'h0);
		rr = ret_a;
		land(12'h200);
		op(PSS_OP_SUBROUTINE_RETURN, 12'h0, 8'h0);
		land(rr);
		wr(12'h040, 32'h85, PSS_RESP_OKAY);
		@(posedge aclk);
		irq <= 6'h05;
		@(posedge aclk);
		irq <= 6'h00;
		land(12'h004);
		rd(12'h040, {PSS_RESP_OKAY, 32'h05});
		rd(12'h044, {PSS_RESP_OKAY, 32'h04});
		wr(12'h044, 32'h04, PSS_RESP_OKAY);
		op(PSS_OP_INTERRUPT_RETURN, 12'h0, 8'h0);
		rd(12'h040, {PSS_RESP_OKAY, 32'h85});
		// nine calls: the first return address is lost, the last eight stay
		for (int k = 0; k < 9; k++)
		begin
			op(PSS_OP_CALL, 12'h300 + 12'(k * 16), 8'h0);
			land(12'h300 + 12'(k * 16));
		end
		irq <= 6'h01;
		@(posedge aclk);
		irq <= 6'h00;
		repeat (8) @(posedge aclk);
		rd(12'h044, {PSS_RESP_OKAY, 32'h01});
		op(PSS_OP_SUBROUTINE_RETURN, 12'h0, 8'h0);
		land(12'h004);
		op(PSS_OP_INTERRUPT_RETURN, 12'h0, 8'h0);
		land(12'h371);
		for (int k = 7; k >= 1; k--)
		begin
			op(PSS_OP_SUBROUTINE_RETURN, 12'h0, 8'h0);
			land(12'h2f1 + 12'(k * 16));
		end
		stop_test();
	end
endmodule : testbench
